// ==== hw/fscr_regs.sv ====
`timescale 1ns/100ps
// Behaviour
// - busy flag shown at status bits 0 and 7 while erase or program runs
// - write-enable latch at bit 1; when clear, write-type commands are refused; config writes are accepted without it
// - write-enable latch cleared by reset, disable, completions, suspend, config writes
// - bit 2 set on suspend during erase, cleared on resume
// - bit 3 set on suspend during program, cleared on resume
// - bit 4 set by protection lock-down, held until power cycle or hardware reset
// - bit 5 set by security-id lockout, never cleared, restored at power-up
// - status byte read-only, bit 6 reads zero
// - status byte readable while an internal operation runs
// - config bit 1 read/write, powers up 0, turns pins into quad lines
// - quad-only commands invalid unless config bit 1 set
// - config bit 1 ignored in four-line command mode; only the quad-command check does so, reset and protect pins still follow it
// - config bit 3 reads 1 until any permanent lock bit set, then 0
// - config bit 6 selects reset (1) or hold (0) pin function
// - hardware protection only while protect pin low and config bit 7 set
// - hardware protection blocks only protection and config register writes
// - changing config bit 7 runs a self-timed write shown as busy
// - config bits 6 and 7 kept across power loss
// - hardware reset clears busy, latch, suspends, lock-down; keeps security lock
// - software reset clears status except bits 4, 5 and clears config bit 1
module fscr_regs #(
	parameter int PROT_EN_LAT_CYC = fscr_pkg::PROT_EN_LAT_CYC
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic clk_link_in,
	input wire logic cmd_strobe_in,
	input wire fscr_pkg::fscr_cmd_t cmd_kind_in,
	input wire logic [7:0] cmd_data_in,
	input wire logic quad_mode_in,
	input wire logic wp_pin_n_in,
	input wire logic hw_reset_pin_n_in,
	input wire logic op_done_in,
	input wire logic nv_sec_in,
	input wire logic nv_reset_or_hold_select_in,
	input wire logic nv_hw_protect_enable_bit_in,
	input wire logic nv_lock_any_in,
	output logic [7:0] status_byte_out,
	output logic [7:0] config_byte_out,
	output logic cmd_invalid_out,
	output logic cmd_rejected_out,
	output fscr_pkg::fscr_evt_t op_event_out,
	output fscr_pkg::fscr_op_t op_kind_out,
	output logic hw_protect_out,
	output logic quad_lines_out,
	output logic reset_pin_enable_out,
	output logic nv_sec_out,
	output logic nv_reset_or_hold_select_out,
	output logic nv_hw_protect_enable_bit_out,
	output logic nv_lock_any_out
);
	if (PROT_EN_LAT_CYC < 1 || PROT_EN_LAT_CYC > (1 << fscr_pkg::LAT_W)) begin : g_chk
		$error("PROT_EN_LAT_CYC out of range");
	end

	localparam logic [fscr_pkg::LAT_W-1:0] LAT_LOAD =
		fscr_pkg::LAT_W'(PROT_EN_LAT_CYC - 1);

	// ---------------- core domain ----------------
	fscr_pkg::fscr_op_t op_state_ff;
	fscr_pkg::fscr_op_t nxt_op_state;
	fscr_pkg::fscr_evt_t op_event_ff;
	logic [fscr_pkg::LAT_W-1:0] lat_cnt_ff;
	logic wel_ff;
	logic wse_ff;
	logic wsp_ff;
	logic protect_lockdown_flag_ff;
	logic sec_ff;
	logic ioc_ff;
	logic no_permanent_lock_bit_ff;
	logic reset_or_hold_select_ff;
	logic hw_protect_enable_bit_ff;
	logic hw_prot_ff;
	logic nv_load_ff;
	logic busy_x_ff;
	logic take;
	logic ack_level;
	logic [1:0] pins_s;
	logic busy;
	logic hw_rst;
	logic soft_rst;
	logic array_done;

	// link-side command hold, stable while a request is pending
	logic req_tgl_ff;
	fscr_pkg::fscr_cmd_t hold_kind_ff;
	logic [7:0] hold_data_ff;

	fscr_toggle_rx u_req_rx (
		.clk_in(clk_sys_in),
		.resetn_in(resetn_in),
		.toggle_in(req_tgl_ff),
		.pulse_out(take),
		.level_out(ack_level)
	);

	fscr_sync #(.W(2)) u_pin_sync (
		.clk_in(clk_sys_in),
		.resetn_in(resetn_in),
		.d_in({hw_reset_pin_n_in, wp_pin_n_in}),
		.q_out(pins_s)
	);

	assign busy = (op_state_ff != fscr_pkg::FSCR_OP_IDLE);
	// shared pin acts as reset only when selected and not a quad line
	assign hw_rst = reset_or_hold_select_ff && !ioc_ff && !pins_s[1];
	assign soft_rst = take && (hold_kind_ff == fscr_pkg::FSCR_CMD_SOFT_RESET);
	assign array_done = op_done_in && busy && (op_state_ff != fscr_pkg::FSCR_OP_CFG_WRITE);

	always_comb begin
		nxt_op_state = op_state_ff;
		case (op_state_ff)
			fscr_pkg::FSCR_OP_IDLE: begin
				if (take) begin
					case (hold_kind_ff)
						fscr_pkg::FSCR_CMD_PAGE_PROG,
						fscr_pkg::FSCR_CMD_QUAD_PAGE_PROG: nxt_op_state = fscr_pkg::FSCR_OP_PROGRAM;
						fscr_pkg::FSCR_CMD_SECTOR_ERASE,
						fscr_pkg::FSCR_CMD_BLOCK_ERASE,
						fscr_pkg::FSCR_CMD_CHIP_ERASE: nxt_op_state = fscr_pkg::FSCR_OP_ERASE;
						fscr_pkg::FSCR_CMD_SID_PROGRAM: nxt_op_state = fscr_pkg::FSCR_OP_SID_PROG;
						fscr_pkg::FSCR_CMD_WR_CONFIG: begin
							if (hold_data_ff[fscr_pkg::CF_HW_PROTECT_ENABLE_BIT] != hw_protect_enable_bit_ff) begin
								nxt_op_state = fscr_pkg::FSCR_OP_CFG_WRITE;
							end
						end
						fscr_pkg::FSCR_CMD_RESUME: begin
							if (wsp_ff) begin
								nxt_op_state = fscr_pkg::FSCR_OP_PROGRAM;
							end else if (wse_ff) begin
								nxt_op_state = fscr_pkg::FSCR_OP_ERASE;
							end
						end
						default: nxt_op_state = fscr_pkg::FSCR_OP_IDLE;
					endcase
				end
			end
			fscr_pkg::FSCR_OP_PROGRAM, fscr_pkg::FSCR_OP_ERASE: begin
				if (take && hold_kind_ff == fscr_pkg::FSCR_CMD_SUSPEND) begin
					nxt_op_state = fscr_pkg::FSCR_OP_IDLE;
				end else if (op_done_in) begin
					nxt_op_state = fscr_pkg::FSCR_OP_IDLE;
				end
			end
			fscr_pkg::FSCR_OP_SID_PROG: begin
				if (op_done_in) begin
					nxt_op_state = fscr_pkg::FSCR_OP_IDLE;
				end
			end
			fscr_pkg::FSCR_OP_CFG_WRITE: begin
				if (lat_cnt_ff == '0) begin
					nxt_op_state = fscr_pkg::FSCR_OP_IDLE;
				end
			end
			default: nxt_op_state = fscr_pkg::FSCR_OP_IDLE;
		endcase
		if (hw_rst || soft_rst) begin
			nxt_op_state = fscr_pkg::FSCR_OP_IDLE;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			op_state_ff <= fscr_pkg::FSCR_OP_IDLE;
			op_event_ff <= fscr_pkg::FSCR_EV_NONE;
			op_kind_out <= fscr_pkg::FSCR_OP_IDLE;
			busy_x_ff <= 1'b0;
		end else begin
			op_state_ff <= nxt_op_state;
			op_kind_out <= nxt_op_state;
			// registered copy, so the crossing never sees a decode glitch
			busy_x_ff <= (nxt_op_state != fscr_pkg::FSCR_OP_IDLE);
			if ((hw_rst || soft_rst) && busy) begin
				op_event_ff <= fscr_pkg::FSCR_EV_ABORT;
			end else if (take && hold_kind_ff == fscr_pkg::FSCR_CMD_RESUME && !busy
					&& nxt_op_state != fscr_pkg::FSCR_OP_IDLE) begin
				op_event_ff <= fscr_pkg::FSCR_EV_RESUME;
			end else if (!busy && nxt_op_state != fscr_pkg::FSCR_OP_IDLE
					&& nxt_op_state != fscr_pkg::FSCR_OP_CFG_WRITE) begin
				op_event_ff <= fscr_pkg::FSCR_EV_START;
			end else if (busy && nxt_op_state == fscr_pkg::FSCR_OP_IDLE && !op_done_in
					&& op_state_ff != fscr_pkg::FSCR_OP_CFG_WRITE) begin
				op_event_ff <= fscr_pkg::FSCR_EV_SUSPEND;
			end else begin
				op_event_ff <= fscr_pkg::FSCR_EV_NONE;
			end
		end
	end
	assign op_event_out = op_event_ff;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lat_cnt_ff <= '0;
		end else if (op_state_ff != fscr_pkg::FSCR_OP_CFG_WRITE) begin
			lat_cnt_ff <= LAT_LOAD;
		end else if (lat_cnt_ff != '0) begin
			lat_cnt_ff <= lat_cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wel_ff <= fscr_pkg::ST_RESET[fscr_pkg::ST_WEL];
		end else if (hw_rst || soft_rst) begin
			wel_ff <= 1'b0;
		end else if (take && hold_kind_ff == fscr_pkg::FSCR_CMD_WR_ENABLE) begin
			// enable wins over a completion in the same cycle
			wel_ff <= 1'b1;
		end else if (array_done) begin
			wel_ff <= 1'b0;
		end else if (take) begin
			case (hold_kind_ff)
				fscr_pkg::FSCR_CMD_WR_DISABLE,
				fscr_pkg::FSCR_CMD_WR_CONFIG,
				fscr_pkg::FSCR_CMD_SUSPEND,
				fscr_pkg::FSCR_CMD_BP_WRITE,
				fscr_pkg::FSCR_CMD_BP_LOCKDOWN,
				fscr_pkg::FSCR_CMD_SID_LOCKOUT: wel_ff <= 1'b0;
				default: wel_ff <= wel_ff;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wse_ff <= fscr_pkg::ST_RESET[fscr_pkg::ST_WSE];
			wsp_ff <= fscr_pkg::ST_RESET[fscr_pkg::ST_WSP];
		end else if (hw_rst || soft_rst) begin
			wse_ff <= 1'b0;
			wsp_ff <= 1'b0;
		end else if (take && hold_kind_ff == fscr_pkg::FSCR_CMD_SUSPEND) begin
			if (op_state_ff == fscr_pkg::FSCR_OP_ERASE) begin
				wse_ff <= 1'b1;
			end
			if (op_state_ff == fscr_pkg::FSCR_OP_PROGRAM) begin
				wsp_ff <= 1'b1;
			end
		end else if (take && hold_kind_ff == fscr_pkg::FSCR_CMD_RESUME && !busy) begin
			if (wsp_ff) begin
				wsp_ff <= 1'b0;
			end else begin
				wse_ff <= 1'b0;
			end
		end
	end

	// power-up load of the retained bits, one cycle after release
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			nv_load_ff <= 1'b1;
		end else begin
			nv_load_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			protect_lockdown_flag_ff <= fscr_pkg::ST_RESET[fscr_pkg::ST_PROTECT_LOCKDOWN_FLAG];
		end else if (hw_rst) begin
			protect_lockdown_flag_ff <= 1'b0;
		end else if (take && hold_kind_ff == fscr_pkg::FSCR_CMD_BP_LOCKDOWN) begin
			protect_lockdown_flag_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sec_ff <= fscr_pkg::ST_RESET[fscr_pkg::ST_SEC];
			no_permanent_lock_bit_ff <= fscr_pkg::CF_RESET[fscr_pkg::CF_NO_PERMANENT_LOCK_BIT];
			reset_or_hold_select_ff <= fscr_pkg::CF_RESET[fscr_pkg::CF_RESET_OR_HOLD_SELECT];
			hw_protect_enable_bit_ff <= fscr_pkg::CF_RESET[fscr_pkg::CF_HW_PROTECT_ENABLE_BIT];
		end else if (nv_load_ff) begin
			sec_ff <= nv_sec_in;
			no_permanent_lock_bit_ff <= !nv_lock_any_in;
			reset_or_hold_select_ff <= nv_reset_or_hold_select_in;
			hw_protect_enable_bit_ff <= nv_hw_protect_enable_bit_in;
		end else if (take) begin
			if (hold_kind_ff == fscr_pkg::FSCR_CMD_SID_LOCKOUT) begin
				sec_ff <= 1'b1;
			end
			if (hold_kind_ff == fscr_pkg::FSCR_CMD_NVLOCK_WRITE) begin
				no_permanent_lock_bit_ff <= 1'b0;
			end
			if (hold_kind_ff == fscr_pkg::FSCR_CMD_WR_CONFIG) begin
				reset_or_hold_select_ff <= hold_data_ff[fscr_pkg::CF_RESET_OR_HOLD_SELECT];
				hw_protect_enable_bit_ff <= hold_data_ff[fscr_pkg::CF_HW_PROTECT_ENABLE_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ioc_ff <= fscr_pkg::CF_RESET[fscr_pkg::CF_IOC];
		end else if (hw_rst || soft_rst) begin
			ioc_ff <= 1'b0;
		end else if (take && hold_kind_ff == fscr_pkg::FSCR_CMD_WR_CONFIG) begin
			ioc_ff <= hold_data_ff[fscr_pkg::CF_IOC];
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hw_prot_ff <= 1'b0;
		end else begin
			// protect pin only exists while not repurposed as a quad line
			hw_prot_ff <= hw_protect_enable_bit_ff && !pins_s[0] && !ioc_ff;
		end
	end

	assign hw_protect_out = hw_prot_ff;
	assign quad_lines_out = ioc_ff;
	assign reset_pin_enable_out = reset_or_hold_select_ff;
	assign nv_sec_out = sec_ff;
	assign nv_reset_or_hold_select_out = reset_or_hold_select_ff;
	assign nv_hw_protect_enable_bit_out = hw_protect_enable_bit_ff;
	assign nv_lock_any_out = !no_permanent_lock_bit_ff;

	// ---------------- link domain ----------------
	logic [fscr_pkg::XS_W-1:0] xs_l;
	logic busy_l;
	logic wel_l;
	logic protect_lockdown_flag_l;
	logic ioc_l;
	logic prot_l;
	logic ack_l;
	logic pending;
	logic quad_only;
	logic write_class;
	logic protect_class;
	logic invalid;
	logic reject;
	logic [7:0] status_ff;
	logic [7:0] config_ff;
	logic invalid_ff;
	logic rejected_ff;

	fscr_sync #(.W(fscr_pkg::XS_W)) u_level_sync (
		.clk_in(clk_link_in),
		.resetn_in(resetn_in),
		.d_in({ack_level, hw_prot_ff, hw_protect_enable_bit_ff, reset_or_hold_select_ff, no_permanent_lock_bit_ff, ioc_ff,
			sec_ff, protect_lockdown_flag_ff, wsp_ff, wse_ff, wel_ff, busy_x_ff}),
		.q_out(xs_l)
	);

	assign busy_l = xs_l[0];
	assign wel_l = xs_l[1];
	assign protect_lockdown_flag_l = xs_l[4];
	assign ioc_l = xs_l[6];
	assign prot_l = xs_l[10];
	assign ack_l = xs_l[11];
	assign pending = req_tgl_ff != ack_l;

	assign quad_only = cmd_kind_in inside {fscr_pkg::FSCR_CMD_QUAD_READ,
		fscr_pkg::FSCR_CMD_QUAD_PAGE_PROG};
	assign write_class = cmd_kind_in inside {fscr_pkg::FSCR_CMD_PAGE_PROG,
		fscr_pkg::FSCR_CMD_QUAD_PAGE_PROG, fscr_pkg::FSCR_CMD_SECTOR_ERASE,
		fscr_pkg::FSCR_CMD_BLOCK_ERASE, fscr_pkg::FSCR_CMD_CHIP_ERASE,
		fscr_pkg::FSCR_CMD_BP_WRITE, fscr_pkg::FSCR_CMD_BP_LOCKDOWN,
		fscr_pkg::FSCR_CMD_SID_PROGRAM, fscr_pkg::FSCR_CMD_SID_LOCKOUT,
		fscr_pkg::FSCR_CMD_NVLOCK_WRITE};
	assign protect_class = cmd_kind_in inside {fscr_pkg::FSCR_CMD_BP_WRITE,
		fscr_pkg::FSCR_CMD_BP_LOCKDOWN, fscr_pkg::FSCR_CMD_WR_CONFIG};
	assign invalid = quad_only && !ioc_l && !quad_mode_in;
	assign reject = pending
		|| (write_class && (!wel_l || busy_l))
		|| (protect_class && prot_l)
		|| (cmd_kind_in == fscr_pkg::FSCR_CMD_BP_WRITE && protect_lockdown_flag_l);

	always_ff @(posedge clk_link_in or negedge resetn_in) begin
		if (!resetn_in) begin
			invalid_ff <= 1'b0;
			rejected_ff <= 1'b0;
			req_tgl_ff <= 1'b0;
			hold_kind_ff <= fscr_pkg::FSCR_CMD_NONE;
			hold_data_ff <= 8'h00;
		end else begin
			invalid_ff <= cmd_strobe_in && invalid;
			rejected_ff <= cmd_strobe_in && !invalid && reject;
			if (cmd_strobe_in && !invalid && !reject
					&& cmd_kind_in != fscr_pkg::FSCR_CMD_QUAD_READ
					&& cmd_kind_in != fscr_pkg::FSCR_CMD_NONE) begin
				hold_kind_ff <= cmd_kind_in;
				hold_data_ff <= cmd_data_in & fscr_pkg::CF_WRITE_MASK;
				req_tgl_ff <= !req_tgl_ff;
			end
		end
	end

	always_ff @(posedge clk_link_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_ff <= fscr_pkg::ST_RESET;
			config_ff <= fscr_pkg::CF_RESET;
		end else begin
			// refreshed every link cycle, so polling works mid-operation
			status_ff <= {xs_l[0], 1'b0, xs_l[5], xs_l[4], xs_l[3],
				xs_l[2], xs_l[1], xs_l[0]};
			config_ff <= {xs_l[9], xs_l[8], 2'b00, xs_l[7], 1'b0,
				xs_l[6], 1'b0};
		end
	end

	assign status_byte_out = status_ff;
	assign config_byte_out = config_ff;
	assign cmd_invalid_out = invalid_ff;
	assign cmd_rejected_out = rejected_ff;

	// ---------------- checks ----------------
	property p_busy_mirror;
		@(posedge clk_link_in) disable iff (!resetn_in)
		status_byte_out[fscr_pkg::ST_BUSY_LO] == status_byte_out[fscr_pkg::ST_BUSY_HI];
	endproperty
	a_busy_mirror: assert property (p_busy_mirror) else $error("busy bits differ");

	property p_wel_reject;
		@(posedge clk_link_in) disable iff (!resetn_in)
		cmd_strobe_in && write_class && !wel_l && !invalid |=> cmd_rejected_out;
	endproperty
	a_wel_reject: assert property (p_wel_reject) else $error("write without latch taken");

	property p_wel_done;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		array_done && !nv_load_ff
			&& !(take && hold_kind_ff == fscr_pkg::FSCR_CMD_WR_ENABLE) |=> !wel_ff;
	endproperty
	a_wel_done: assert property (p_wel_done) else $error("latch kept after completion");

	sequence s_suspend_erase;
		take && hold_kind_ff == fscr_pkg::FSCR_CMD_SUSPEND
			&& op_state_ff == fscr_pkg::FSCR_OP_ERASE && !hw_rst;
	endsequence
	property p_erase_susp;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		s_suspend_erase |=> wse_ff && !busy && op_event_out == fscr_pkg::FSCR_EV_SUSPEND;
	endproperty
	a_erase_susp: assert property (p_erase_susp) else $error("erase suspend missed");

	property p_prog_susp;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		take && hold_kind_ff == fscr_pkg::FSCR_CMD_SUSPEND
			&& op_state_ff == fscr_pkg::FSCR_OP_PROGRAM && !hw_rst |=> wsp_ff && !busy;
	endproperty
	a_prog_susp: assert property (p_prog_susp) else $error("program suspend missed");

	property p_lockdown_hold;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		protect_lockdown_flag_ff && !hw_rst |=> protect_lockdown_flag_ff;
	endproperty
	a_lockdown_hold: assert property (p_lockdown_hold) else $error("lock-down lost");

	property p_sec_sticky;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		sec_ff && !nv_load_ff |=> sec_ff [*8];
	endproperty
	a_sec_sticky: assert property (p_sec_sticky) else $error("security lock cleared");

	property p_reserved_zero;
		@(posedge clk_link_in) disable iff (!resetn_in)
		status_byte_out[fscr_pkg::ST_RES] == 1'b0 && config_byte_out[0] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_quad_invalid;
		@(posedge clk_link_in) disable iff (!resetn_in)
		cmd_strobe_in && quad_only && !ioc_l && !quad_mode_in
			|=> cmd_invalid_out && $stable(req_tgl_ff);
	endproperty
	a_quad_invalid: assert property (p_quad_invalid) else $error("quad command accepted");

	property p_hw_protect_enable_bit_busy;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		$changed(hw_protect_enable_bit_ff) && !nv_load_ff && !$past(nv_load_ff) |-> busy;
	endproperty
	a_hw_protect_enable_bit_busy: assert property (p_hw_protect_enable_bit_busy) else $error("protect change not timed");

	property p_soft_reset;
		@(posedge clk_sys_in) disable iff (!resetn_in)
		soft_rst |=> !wel_ff && !wse_ff && !wsp_ff && !ioc_ff && !busy
			&& protect_lockdown_flag_ff == $past(protect_lockdown_flag_ff);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");
endmodule

// ==== include/fscr_pkg.sv ====
package fscr_pkg;
	// status byte field positions
	localparam int ST_BUSY_LO = 0;
	localparam int ST_WEL = 1;
	localparam int ST_WSE = 2;
	localparam int ST_WSP = 3;
	localparam int ST_PROTECT_LOCKDOWN_FLAG = 4;
	localparam int ST_SEC = 5;
	localparam int ST_RES = 6;
	localparam int ST_BUSY_HI = 7;
	// configuration byte field positions
	localparam int CF_IOC = 1;
	localparam int CF_NO_PERMANENT_LOCK_BIT = 3;
	localparam int CF_RESET_OR_HOLD_SELECT = 6;
	localparam int CF_HW_PROTECT_ENABLE_BIT = 7;
	// power-up values
	localparam logic [7:0] ST_RESET = 8'h00;
	localparam logic [7:0] CF_RESET = 8'h08;
	// bits a configuration write may change
	localparam logic [7:0] CF_WRITE_MASK = 8'hc2;
	// self-timed write after a protect-enable change
	localparam int SYS_CLK_MHZ = 250;
	localparam int PROT_EN_LAT_NS = 10000;
	localparam int PROT_EN_LAT_CYC = (PROT_EN_LAT_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int LAT_W = 16;
	// levels carried from the core to the link side
	localparam int XS_W = 12;

	typedef enum logic [4:0] {
		FSCR_CMD_NONE,
		FSCR_CMD_WR_ENABLE,
		FSCR_CMD_WR_DISABLE,
		FSCR_CMD_WR_CONFIG,
		FSCR_CMD_SUSPEND,
		FSCR_CMD_RESUME,
		FSCR_CMD_PAGE_PROG,
		FSCR_CMD_QUAD_PAGE_PROG,
		FSCR_CMD_SECTOR_ERASE,
		FSCR_CMD_BLOCK_ERASE,
		FSCR_CMD_CHIP_ERASE,
		FSCR_CMD_BP_WRITE,
		FSCR_CMD_BP_LOCKDOWN,
		FSCR_CMD_SID_PROGRAM,
		FSCR_CMD_SID_LOCKOUT,
		FSCR_CMD_NVLOCK_WRITE,
		FSCR_CMD_SOFT_RESET,
		FSCR_CMD_QUAD_READ
	} fscr_cmd_t;

	typedef enum logic [2:0] {
		FSCR_OP_IDLE,
		FSCR_OP_PROGRAM,
		FSCR_OP_ERASE,
		FSCR_OP_SID_PROG,
		FSCR_OP_CFG_WRITE
	} fscr_op_t;

	typedef enum logic [2:0] {
		FSCR_EV_NONE,
		FSCR_EV_START,
		FSCR_EV_SUSPEND,
		FSCR_EV_RESUME,
		FSCR_EV_ABORT
	} fscr_evt_t;
endpackage

// ==== hw/fscr_sync.sv ====
`timescale 1ns/100ps
module fscr_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule

// ==== hw/fscr_toggle_rx.sv ====
`timescale 1ns/100ps
module fscr_toggle_rx (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic toggle_in,
	output logic pulse_out,
	output logic level_out
);
	logic meta_ff;
	logic sync_ff;
	logic seen_ff;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			seen_ff <= 1'b0;
		end else begin
			meta_ff <= toggle_in;
			sync_ff <= meta_ff;
			seen_ff <= sync_ff;
		end
	end

	// one pulse per toggle; level is the acknowledged toggle value
	assign pulse_out = sync_ff ^ seen_ff;
	assign level_out = seen_ff;
endmodule

// ==== test/fscr_host_model.sv ====
`timescale 1ns/100ps
module fscr_host_model (
	input wire logic clk_link_in,
	input wire logic cmd_rejected_in,
	input wire logic cmd_invalid_in,
	input wire logic [7:0] status_in,
	output logic cmd_strobe_out,
	output fscr_pkg::fscr_cmd_t cmd_kind_out,
	output logic [7:0] cmd_data_out
);
	initial begin
		cmd_strobe_out = 1'b0;
		cmd_kind_out = fscr_pkg::FSCR_CMD_NONE;
		cmd_data_out = 8'h00;
	end
	// one command, answer taken just after the strobe drops, then spacing
	task automatic send(input fscr_pkg::fscr_cmd_t kind, input logic [7:0] data,
			output logic rej, output logic inv);
		@(posedge clk_link_in);
		#1;
		cmd_strobe_out = 1'b1;
		cmd_kind_out = kind;
		cmd_data_out = data;
		@(posedge clk_link_in);
		#1;
		cmd_strobe_out = 1'b0;
		cmd_kind_out = fscr_pkg::FSCR_CMD_NONE;
		cmd_data_out = ~data;
		rej = cmd_rejected_in;
		inv = cmd_invalid_in;
		repeat (12) @(posedge clk_link_in);
		#1;
	endtask
	// busy poll, bounded
	task automatic wait_idle(output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 300 && !ok; i++) begin
			@(posedge clk_link_in);
			#1;
			ok = (status_in[0] === 1'b0);
		end
		#1;
	endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
	logic clk_sys_in, clk_link_in, resetn_in, quad_mode_in, wp_pin_n_in, op_done_in;
	logic nv_sec_in, nv_reset_or_hold_select_in, nv_hw_protect_enable_bit_in, nv_lock_any_in, cmd_strobe_in;
	logic cmd_invalid_out, cmd_rejected_out, hw_protect_out, quad_lines_out, nv_sec_out;
	logic hw_reset_pin_n_in, reset_pin_enable_out, nv_reset_or_hold_select_out, nv_hw_protect_enable_bit_out, nv_lock_any_out;
	fscr_pkg::fscr_op_t op_kind_out;
	logic [7:0] cmd_data_in, status_byte_out, config_byte_out;
	fscr_pkg::fscr_cmd_t cmd_kind_in;
	int errors = 0;
	int comparisons = 0;

	fscr_regs #(.PROT_EN_LAT_CYC(4)) u_dut (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_link_in(clk_link_in),
		.cmd_strobe_in(cmd_strobe_in), .cmd_kind_in(cmd_kind_in), .cmd_data_in(cmd_data_in),
		.quad_mode_in(quad_mode_in), .wp_pin_n_in(wp_pin_n_in),
		.hw_reset_pin_n_in(hw_reset_pin_n_in),
		.op_done_in(op_done_in), .nv_sec_in(nv_sec_in), .nv_reset_or_hold_select_in(nv_reset_or_hold_select_in),
		.nv_hw_protect_enable_bit_in(nv_hw_protect_enable_bit_in), .nv_lock_any_in(nv_lock_any_in),
		.status_byte_out(status_byte_out), .config_byte_out(config_byte_out),
		.cmd_invalid_out(cmd_invalid_out), .cmd_rejected_out(cmd_rejected_out),
		.op_event_out(), .op_kind_out(op_kind_out), .hw_protect_out(hw_protect_out),
		.quad_lines_out(quad_lines_out), .reset_pin_enable_out(reset_pin_enable_out),
		.nv_sec_out(nv_sec_out), .nv_reset_or_hold_select_out(nv_reset_or_hold_select_out), .nv_hw_protect_enable_bit_out(nv_hw_protect_enable_bit_out),
		.nv_lock_any_out(nv_lock_any_out)
	);
	fscr_host_model u_host (
		.clk_link_in(clk_link_in), .cmd_rejected_in(cmd_rejected_out),
		.cmd_invalid_in(cmd_invalid_out), .status_in(status_byte_out),
		.cmd_strobe_out(cmd_strobe_in), .cmd_kind_out(cmd_kind_in), .cmd_data_out(cmd_data_in)
	);

	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		clk_link_in = 1'b0;
		#3.3;
		forever #7.5 clk_link_in = ~clk_link_in;
	end

	task automatic test_done();
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input fscr_pkg::fscr_cmd_t k, input logic [7:0] d,
			input logic erej, input logic einv);
		logic rej, inv;
		u_host.send(k, d, rej, inv);
		chk({6'h00, rej, inv}, {6'h00, erej, einv});
	endtask
	task automatic idle();
		logic ok;
		u_host.wait_idle(ok);
		chk({7'h00, ok}, 8'h01);
	endtask
	task automatic do_reset();
		resetn_in = 1'b0;
		repeat (5) @(posedge clk_sys_in);
		#1;
		resetn_in = 1'b1;
		repeat (10) @(posedge clk_link_in);
		#1;
	endtask
	task automatic done_pulse();
		@(posedge clk_sys_in);
		#1;
		op_done_in = 1'b1;
		@(posedge clk_sys_in);
		#1;
		op_done_in = 1'b0;
	endtask

	task automatic t_reset();
		chk(status_byte_out, 8'h00);
		chk(config_byte_out, 8'h08);
		cmd(fscr_pkg::FSCR_CMD_PAGE_PROG, 8'h00, 1'b1, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_WR_ENABLE, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out, 8'h02);
		cmd(fscr_pkg::FSCR_CMD_WR_DISABLE, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out, 8'h00);
	endtask
	task automatic t_suspend(input fscr_pkg::fscr_cmd_t k, input logic [7:0] sbit);
		cmd(fscr_pkg::FSCR_CMD_WR_ENABLE, 8'h00, 1'b0, 1'b0);
		cmd(k, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out, 8'h83);
		cmd(fscr_pkg::FSCR_CMD_SUSPEND, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out & (sbit | 8'h02), sbit);
		cmd(fscr_pkg::FSCR_CMD_RESUME, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out & (sbit | 8'h81), 8'h81);
		done_pulse();
		idle();
		repeat (8) @(posedge clk_link_in);
		#1;
		chk(status_byte_out, 8'h00);
	endtask
	task automatic t_config();
		cmd(fscr_pkg::FSCR_CMD_WR_CONFIG, 8'hff, 1'b0, 1'b0);
		idle();
		chk(config_byte_out, 8'hca);
		chk({7'h00, quad_lines_out}, 8'h01);
		cmd(fscr_pkg::FSCR_CMD_QUAD_READ, 8'h00, 1'b0, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_WR_CONFIG, 8'h80, 1'b0, 1'b0);
		idle();
		cmd(fscr_pkg::FSCR_CMD_QUAD_READ, 8'h00, 1'b0, 1'b1);
		quad_mode_in = 1'b1;
		cmd(fscr_pkg::FSCR_CMD_QUAD_READ, 8'h00, 1'b0, 1'b0);
		quad_mode_in = 1'b0;
		wp_pin_n_in = 1'b0;
		repeat (8) @(posedge clk_sys_in);
		#1;
		chk({7'h00, hw_protect_out}, 8'h01);
		cmd(fscr_pkg::FSCR_CMD_WR_CONFIG, 8'h00, 1'b1, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_WR_ENABLE, 8'h00, 1'b0, 1'b0);
		wp_pin_n_in = 1'b1;
		// pin release must cross both domains before the write
		repeat (8) @(posedge clk_link_in);
		#1;
		cmd(fscr_pkg::FSCR_CMD_WR_CONFIG, 8'h00, 1'b0, 1'b0);
		idle();
		chk({7'h00, hw_protect_out}, 8'h00);
		chk(config_byte_out, 8'h08);
		chk(status_byte_out, 8'h00);
	endtask
	task automatic t_hwreset();
		cmd(fscr_pkg::FSCR_CMD_WR_CONFIG, 8'h40, 1'b0, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_WR_ENABLE, 8'h00, 1'b0, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_PAGE_PROG, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out, 8'h83);
		chk({5'h00, op_kind_out}, {5'h00, fscr_pkg::FSCR_OP_PROGRAM});
		hw_reset_pin_n_in = 1'b0;
		repeat (8) @(posedge clk_sys_in);
		#1;
		hw_reset_pin_n_in = 1'b1;
		repeat (8) @(posedge clk_link_in);
		#1;
		chk(status_byte_out, 8'h00);
		chk({5'h00, op_kind_out}, {5'h00, fscr_pkg::FSCR_OP_IDLE});
		chk(config_byte_out, 8'h48);
		cmd(fscr_pkg::FSCR_CMD_WR_CONFIG, 8'h00, 1'b0, 1'b0);
	endtask
	task automatic t_locks();
		cmd(fscr_pkg::FSCR_CMD_WR_ENABLE, 8'h00, 1'b0, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_SID_LOCKOUT, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out, 8'h20);
		chk({7'h00, nv_sec_out}, 8'h01);
		cmd(fscr_pkg::FSCR_CMD_WR_ENABLE, 8'h00, 1'b0, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_BP_LOCKDOWN, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out, 8'h30);
		cmd(fscr_pkg::FSCR_CMD_WR_CONFIG, 8'h02, 1'b0, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_WR_ENABLE, 8'h00, 1'b0, 1'b0);
		cmd(fscr_pkg::FSCR_CMD_SOFT_RESET, 8'h00, 1'b0, 1'b0);
		chk(status_byte_out, 8'h30);
		chk(config_byte_out, 8'h08);
	endtask
	task automatic t_power();
		nv_sec_in = 1'b1;
		nv_reset_or_hold_select_in = 1'b1;
		nv_lock_any_in = 1'b1;
		do_reset();
		chk(status_byte_out, 8'h20);
		chk(config_byte_out, 8'h40);
		chk({4'h0, reset_pin_enable_out, nv_reset_or_hold_select_out, nv_hw_protect_enable_bit_out, nv_lock_any_out},
			8'h0d);
	endtask

	initial begin
		{quad_mode_in, op_done_in, nv_sec_in, nv_reset_or_hold_select_in, nv_hw_protect_enable_bit_in} = 5'h00;
		nv_lock_any_in = 1'b0;
		wp_pin_n_in = 1'b1;
		hw_reset_pin_n_in = 1'b1;
		do_reset();
		t_reset();
		t_suspend(fscr_pkg::FSCR_CMD_PAGE_PROG, 8'h08);
		t_suspend(fscr_pkg::FSCR_CMD_SECTOR_ERASE, 8'h04);
		t_config();
		t_hwreset();
		t_locks();
		t_power();
		test_done();
	end
	initial begin
		#60000;
		errors++;
		test_done();
	end
endmodule
